// ==== fbg_pkg.sv ====
// Constants, types and field layout for the fractional baud generator
// Overview of operation
// - Prescaler divides input clock by one or four
// - Divisor spans one to 65535.9375 in sixteenths
// - Sampling tick times transmit shifting and receive sampling
// - Reset divisor: low one, high zero, fraction zero
// - Integer from two bytes, fraction low nibble
// - Rate select: one gives 16X, zero 8X
// - 8X with odd fraction may jitter sixteenth
// - Eight bit shifter fed by 64 byte FIFO
// - Bit lasts 16 or 8 sampling ticks
// - Frame: start, data, optional parity, stop bits
// - Data leaves least significant bit first
// - Status bit 5 holding, bit 6 shifter
// - FIFO mode write stores byte, bumps pointer
// - Holding-empty flag set when FIFO empty
// - Shifter-empty flag set once frame fully sent and holding-empty set
package fbg_pkg;
  // Host register addresses on the 3-bit port
  localparam logic [2:0] ADDR_HOLD      = 3'h0;
  localparam logic [2:0] ADDR_DIV_LOW   = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH  = 3'h1;
  localparam logic [2:0] ADDR_QCTL      = 3'h2;
  localparam logic [2:0] ADDR_LCTL      = 3'h3;
  localparam logic [2:0] ADDR_MISC      = 3'h4;
  localparam logic [2:0] ADDR_LSTATE    = 3'h5;
  localparam logic [2:0] ADDR_EXT_SEL   = 3'h6;
  localparam logic [2:0] ADDR_DIV_FRAC  = 3'h7;
  // Reset values
  localparam logic [7:0] DIV_LOW_RST    = 8'h01;
  localparam logic [7:0] DIV_HIGH_RST   = 8'h00;
  localparam logic [3:0] DIV_FRAC_RST   = 4'h0;
  localparam logic [7:0] LCTL_RST       = 8'h03;
  // Field positions
  localparam int MISC_PRESCALE_BIT  = 7;
  localparam int EXT_RATE16_BIT     = 7;
  localparam int QCTL_FIFO_EN_BIT   = 0;
  localparam int QCTL_TX_CLR_BIT    = 2;
  localparam int LCTL_STOP_BIT      = 2;
  localparam int LCTL_PAR_EN_BIT    = 3;
  localparam int LCTL_PAR_EVEN_BIT  = 4;
  localparam int LCTL_ACCESS_BIT    = 7;
  localparam int LST_HOLD_EMPTY_BIT = 5;
  localparam int LST_TX_EMPTY_BIT   = 6;
  // Timing
  localparam logic [1:0] PRESCALE_DIV4  = 2'h3;
  localparam logic [4:0] TICKS_16X      = 5'h10;
  localparam logic [4:0] TICKS_8X       = 5'h08;
  localparam int         TX_FIFO_DEPTH  = 64;

  typedef enum logic [4:0] {
    FBG_IDLE   = 5'b00001,
    FBG_START  = 5'b00010,
    FBG_DATA   = 5'b00100,
    FBG_PARITY = 5'b01000,
    FBG_STOP   = 5'b10000
  } fbg_tx_state_e;

  typedef struct packed {
    logic [1:0] word_len;
    logic       two_stop;
    logic       par_en;
    logic       par_even;
  } fbg_frame_s;
endpackage : fbg_pkg

// ==== fbg_fifo.sv ====
// Parameterised valid/ready FIFO for transmit bytes
module fbg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clr,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready,
  // Status
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign empty     = (cnt_r == '0);
  assign out_data  = mem[rd_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || clr) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a : assert property (@(posedge clk) disable iff (sys_rst)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count overflow");
endmodule : fbg_fifo

// ==== fbg_rate_gen.sv ====
// Prescaler and fractional divisor producing the sampling tick
module fbg_rate_gen (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Setup
  input  wire logic        prescale4,
  input  wire logic [15:0] div_int,
  input  wire logic [3:0]  div_frac,
  // Output
  output logic             tick
);
  logic [1:0]  pre_r;
  logic [15:0] cnt_r;
  logic [3:0]  acc_r;
  logic        stretch_r;
  logic        tick_r;
  wire         pre_tick = prescale4 ? (pre_r == fbg_pkg::PRESCALE_DIV4)
                                    : 1'b1;
  // A zero integer is treated as one to keep the tick alive
  wire  [15:0] div_eff  = (div_int == '0) ? 16'h0001 : div_int;
  wire  [15:0] last_cnt = stretch_r ? div_eff : div_eff - 16'h0001;
  wire         wrap     = pre_tick && (cnt_r >= last_cnt);
  wire  [4:0]  acc_sum  = {1'b0, acc_r} + {1'b0, div_frac};

  assign tick = tick_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre_r     <= '0;
      cnt_r     <= '0;
      acc_r     <= '0;
      stretch_r <= 1'b0;
      tick_r    <= 1'b0;
    end else begin
      pre_r  <= prescale4 ? pre_r + 2'h1 : 2'h0;
      tick_r <= wrap;
      if (wrap) begin
        cnt_r     <= '0;
        // In 8X an odd fraction leaves a one-sixteenth bit jitter
        acc_r     <= acc_sum[3:0];
        // Carry out of the accumulator adds one prescaled cycle
        stretch_r <= acc_sum[4];
      end else if (pre_tick) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule : fbg_rate_gen

// ==== fbg_uart_tx.sv ====
// Register port, rate generator and transmit front end
module fbg_uart_tx #(
  parameter int FIFO_DEPTH = fbg_pkg::TX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Host register port
  input  wire logic [2:0] addr,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  // Serial line and status
  output logic            tx_out,
  output logic            sample_tick
);
  // Registers
  logic [7:0] div_low_r;
  logic [7:0] div_high_r;
  logic [3:0] div_frac_r;
  logic [7:0] lctl_r;
  logic       prescale_r;
  logic       rate16_r;
  logic       fifo_en_r;
  logic       hold_full_r;
  logic [7:0] hold_r;
  logic [7:0] rd_data_r;
  logic       tx_r;
  logic       tick_out_r;
  // Transmitter
  fbg_pkg::fbg_tx_state_e state_r;
  fbg_pkg::fbg_tx_state_e state_nxt;
  logic [7:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic [4:0] tick_cnt_r;
  logic       parity_r;
  logic       stop2_r;
  fbg_pkg::fbg_frame_s frame;

  wire tick;
  wire dlab        = lctl_r[fbg_pkg::LCTL_ACCESS_BIT];
  wire wr_hold     = wr_en && !dlab && addr == fbg_pkg::ADDR_HOLD;
  wire wr_div_low  = wr_en && dlab && addr == fbg_pkg::ADDR_DIV_LOW;
  wire wr_div_high = wr_en && dlab && addr == fbg_pkg::ADDR_DIV_HIGH;
  wire wr_div_frac = wr_en && addr == fbg_pkg::ADDR_DIV_FRAC;
  wire wr_qctl     = wr_en && addr == fbg_pkg::ADDR_QCTL;
  wire wr_lctl     = wr_en && addr == fbg_pkg::ADDR_LCTL;
  wire wr_misc     = wr_en && addr == fbg_pkg::ADDR_MISC;
  wire wr_ext      = wr_en && addr == fbg_pkg::ADDR_EXT_SEL;
  wire tx_clr      = wr_qctl && wr_data[fbg_pkg::QCTL_TX_CLR_BIT];

  // FIFO and single holding byte share one source into the shifter
  wire       fifo_in_ready;
  wire       fifo_valid;
  wire [7:0] fifo_data;
  wire       fifo_empty;
  wire       src_valid = fifo_en_r ? fifo_valid : hold_full_r;
  wire [7:0] src_data  = fifo_en_r ? fifo_data : hold_r;
  wire [4:0] bit_ticks = rate16_r ? fbg_pkg::TICKS_16X
                                  : fbg_pkg::TICKS_8X;
  wire       bit_end   = tick && (tick_cnt_r == bit_ticks - 5'h01);
  wire       load      = (state_r == fbg_pkg::FBG_IDLE) && src_valid;
  wire [2:0] last_bit  = {1'b1, frame.word_len};
  wire       hold_empty = fifo_en_r ? fifo_empty : !hold_full_r;
  wire       tx_empty   = hold_empty &&
                          (state_r == fbg_pkg::FBG_IDLE);
  wire [7:0] lstate = {1'b0, tx_empty, hold_empty, 5'h00};
  wire [7:0] rd_mux =
    (addr == fbg_pkg::ADDR_DIV_LOW  && dlab) ? div_low_r  :
    (addr == fbg_pkg::ADDR_DIV_HIGH && dlab) ? div_high_r :
    (addr == fbg_pkg::ADDR_DIV_FRAC) ? {4'h0, div_frac_r} :
    (addr == fbg_pkg::ADDR_LCTL)     ? lctl_r             :
    (addr == fbg_pkg::ADDR_MISC)     ? {prescale_r, 7'h00} :
    (addr == fbg_pkg::ADDR_LSTATE)   ? lstate             :
    (addr == fbg_pkg::ADDR_EXT_SEL)  ? {rate16_r, 7'h00}  : 8'h00;

  assign frame          = {lctl_r[1:0],
                           lctl_r[fbg_pkg::LCTL_STOP_BIT],
                           lctl_r[fbg_pkg::LCTL_PAR_EN_BIT],
                           lctl_r[fbg_pkg::LCTL_PAR_EVEN_BIT]};
  assign rd_data        = rd_data_r;
  assign tx_out         = tx_r;
  assign sample_tick    = tick_out_r;

  fbg_rate_gen u_rate (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .prescale4 (prescale_r),
    .div_int   ({div_high_r, div_low_r}),
    .div_frac  (div_frac_r),
    .tick      (tick)
  );

  // Writes while full are dropped, as with a real overrun
  fbg_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clr       (tx_clr),
    .in_valid  (wr_hold && fifo_en_r),
    .in_data   (wr_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_en_r && load),
    .empty     (fifo_empty)
  );

  // Register file
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_low_r  <= fbg_pkg::DIV_LOW_RST;
      div_high_r <= fbg_pkg::DIV_HIGH_RST;
      div_frac_r <= fbg_pkg::DIV_FRAC_RST;
      lctl_r     <= fbg_pkg::LCTL_RST;
      prescale_r <= 1'b0;
      rate16_r   <= 1'b1;
      fifo_en_r  <= 1'b0;
    end else begin
      if (wr_div_low)  div_low_r  <= wr_data;
      if (wr_div_high) div_high_r <= wr_data;
      if (wr_div_frac) div_frac_r <= wr_data[3:0];
      if (wr_lctl)     lctl_r     <= wr_data;
      if (wr_misc) prescale_r <= wr_data[fbg_pkg::MISC_PRESCALE_BIT];
      if (wr_ext)  rate16_r   <= wr_data[fbg_pkg::EXT_RATE16_BIT];
      if (wr_qctl) fifo_en_r  <= wr_data[fbg_pkg::QCTL_FIFO_EN_BIT];
    end
  end

  // Non-FIFO holding byte; a new write beats the load of the old one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_r      <= 8'h00;
      hold_full_r <= 1'b0;
      rd_data_r   <= 8'h00;
      tick_out_r  <= 1'b0;
    end else begin
      if (wr_hold && !fifo_en_r) begin
        hold_r      <= wr_data;
        hold_full_r <= 1'b1;
      end else if (load && !fifo_en_r) begin
        hold_full_r <= 1'b0;
      end
      if (rd_en) rd_data_r <= rd_mux;
      tick_out_r <= tick;
    end
  end

  // Frame sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fbg_pkg::FBG_IDLE:   if (load) state_nxt = fbg_pkg::FBG_START;
      fbg_pkg::FBG_START:  if (bit_end) state_nxt = fbg_pkg::FBG_DATA;
      fbg_pkg::FBG_DATA:
        if (bit_end && bit_cnt_r == last_bit) begin
          state_nxt = frame.par_en ? fbg_pkg::FBG_PARITY
                                   : fbg_pkg::FBG_STOP;
        end
      fbg_pkg::FBG_PARITY: if (bit_end) state_nxt = fbg_pkg::FBG_STOP;
      fbg_pkg::FBG_STOP:
        if (bit_end && !stop2_r) state_nxt = fbg_pkg::FBG_IDLE;
      default:             state_nxt = fbg_pkg::FBG_IDLE;
    endcase
  end

  // Shifter; start aligns to the next tick, so the first bit may be
  // short by under one tick period
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r    <= fbg_pkg::FBG_IDLE;
      shift_r    <= 8'h00;
      bit_cnt_r  <= 3'h0;
      tick_cnt_r <= 5'h00;
      parity_r   <= 1'b0;
      stop2_r    <= 1'b0;
      tx_r       <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (load) begin
        shift_r    <= src_data;
        tick_cnt_r <= 5'h00;
        bit_cnt_r  <= 3'h0;
        parity_r   <= !frame.par_even;
        stop2_r    <= frame.two_stop;
      end else if (tick) begin
        tick_cnt_r <= bit_end ? 5'h00 : tick_cnt_r + 5'h01;
      end
      if (bit_end && state_r == fbg_pkg::FBG_DATA) begin
        shift_r   <= {1'b0, shift_r[7:1]};
        parity_r  <= parity_r ^ shift_r[0];
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (bit_end && state_r == fbg_pkg::FBG_STOP && stop2_r) begin
        stop2_r <= 1'b0;
      end
      case (state_nxt)
        fbg_pkg::FBG_START:  tx_r <= 1'b0;
        fbg_pkg::FBG_DATA:   tx_r <= (state_r == fbg_pkg::FBG_DATA &&
                                      !bit_end) ? tx_r :
                                      (state_r == fbg_pkg::FBG_DATA ?
                                       shift_r[1] : shift_r[0]);
        fbg_pkg::FBG_PARITY: tx_r <= parity_r ^ shift_r[0];
        default:             tx_r <= 1'b1;
      endcase
    end
  end

  start_low_a : assert property (@(posedge clk) disable iff (sys_rst)
    load |=> !tx_r) else $error("start bit not low");
  bit_len_a : assert property (@(posedge clk) disable iff (sys_rst)
    state_r != fbg_pkg::FBG_IDLE |-> tick_cnt_r < bit_ticks)
    else $error("bit length wrong");
  div_reset_a : assert property (@(posedge clk)
    $past(sys_rst) |-> div_low_r == 8'h01 && div_high_r == 8'h00 &&
    div_frac_r == 4'h0) else $error("divisor reset wrong");
  frac_zero_a : assert property (@(posedge clk) disable iff (sys_rst)
    rd_en && addr == fbg_pkg::ADDR_DIV_FRAC |=> rd_data_r[7:4] == 4'h0)
    else $error("fraction upper bits nonzero");
  hold_flag_a : assert property (@(posedge clk) disable iff (sys_rst)
    rd_en && fifo_en_r && addr == fbg_pkg::ADDR_LSTATE |=>
    rd_data_r[fbg_pkg::LST_HOLD_EMPTY_BIT] == $past(fifo_empty))
    else $error("holding empty flag wrong");
  txe_flag_a : assert property (@(posedge clk) disable iff (sys_rst)
    tx_empty |-> state_r == fbg_pkg::FBG_IDLE && tx_r)
    else $error("shifter empty while busy");
  fifo_write_a : assert property (@(posedge clk) disable iff (sys_rst)
    wr_hold && fifo_en_r && fifo_in_ready && !tx_clr |=> !fifo_empty)
    else $error("fifo write lost");
  idle_high_a : assert property (@(posedge clk) disable iff (sys_rst)
    state_r == fbg_pkg::FBG_IDLE && !$past(load) |-> tx_r)
    else $error("line not idle high");
endmodule : fbg_uart_tx

// ==== fbg_line_model.sv ====
// Behavioural serial receiver standing on the transmit line
module fbg_line_model (
  // Clock and line
  input  wire logic       clk,
  input  wire logic       tick,
  input  wire logic       line,
  // Frame setup
  input  wire logic [4:0] bit_ticks,
  input  wire logic       par_en,
  // Decoded result
  output logic      [7:0] got_byte,
  output logic            got_valid,
  output logic            bad_frame
);
  int i;

  // Counts sampling ticks; a wrong bit length shifts every later sample
  task automatic ticks(input int n);
    int k;
    k = 0;
    while (k < n) begin
      @(posedge clk);
      #1;
      if (tick === 1'b1) k++;
    end
  endtask : ticks

  initial begin
    {got_byte, got_valid, bad_frame} = '0;
    forever begin
      @(posedge clk);
      #1;
      if (line === 1'b0) begin
        // Mid-bit sampling tolerates a start bit short by one tick
        ticks(int'(bit_ticks) / 2);
        bad_frame = (line !== 1'b0);
        for (i = 0; i < 8; i++) begin
          ticks(int'(bit_ticks));
          got_byte[i] = line;
        end
        if (par_en) begin
          ticks(int'(bit_ticks));
          if (line !== ^got_byte) bad_frame = 1'b1;
        end
        ticks(int'(bit_ticks));
        if (line !== 1'b1) bad_frame = 1'b1;
        got_valid = 1'b1;
        @(posedge clk);
        #1;
        got_valid = 1'b0;
      end
    end
  end
endmodule : fbg_line_model

// ==== tb_fractional_baud_gen_and_tx_front.sv ====
// Self-checking bench for the rate generator and transmit front end
module tb_fractional_baud_gen_and_tx_front;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, sys_rst, wr_en, rd_en, tx_out, sample_tick;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, got_byte, r;
  logic       got_valid, bad_frame, par_en;
  logic [4:0] bit_ticks;
  logic [8:0] rxq[$];
  int         n_errors, tests_run;

  fbg_uart_tx dut (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
    .tx_out(tx_out), .sample_tick(sample_tick));
  fbg_line_model line_rx (.clk(clk), .tick(sample_tick), .line(tx_out),
    .bit_ticks(bit_ticks), .par_en(par_en), .got_byte(got_byte),
    .got_valid(got_valid), .bad_frame(bad_frame));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge got_valid) rxq.push_back({bad_frame, got_byte});

  task automatic chk(input string nm, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {addr, wr_data, wr_en} = {a, d, 1'b1};
    @(posedge clk);
    #1 wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    #1 {addr, rd_en} = {a, 1'b1};
    @(posedge clk);
    #1 rd_en = 1'b0;
    r = rd_data;
  endtask : rd

  task automatic wait_rx(input int n);
    int c;
    c = 0;
    while (rxq.size() < n && c < 20000) begin
      @(posedge clk);
      c++;
    end
    chk("frames received", n, rxq.size());
  endtask : wait_rx

  // Divisor given in sixteenths, split the way host software does
  task automatic set_div(input int x16);
    wr(fbg_pkg::ADDR_LCTL, 8'h83);
    wr(fbg_pkg::ADDR_DIV_HIGH, 8'((x16 / 16) >> 8));
    wr(fbg_pkg::ADDR_DIV_LOW, 8'((x16 / 16) & 8'hff));
    wr(fbg_pkg::ADDR_DIV_FRAC, 8'(x16 % 16));
    wr(fbg_pkg::ADDR_LCTL, 8'h03);
  endtask : set_div

  task automatic t_reset();
    wr(fbg_pkg::ADDR_LCTL, 8'h83);
    rd(fbg_pkg::ADDR_DIV_LOW);
    chk("div low", 8'h01, r);
    rd(fbg_pkg::ADDR_DIV_HIGH);
    chk("div high", 8'h00, r);
    rd(fbg_pkg::ADDR_DIV_FRAC);
    chk("div frac", 8'h00, r);
    wr(fbg_pkg::ADDR_DIV_FRAC, 8'hf5);
    rd(fbg_pkg::ADDR_DIV_FRAC);
    chk("frac upper", 8'h05, r);
    wr(fbg_pkg::ADDR_DIV_FRAC, 8'h00);
    wr(fbg_pkg::ADDR_LCTL, 8'h03);
  endtask : t_reset

  // Sixteen ticks hold exactly x16 prescaled cycles, whatever the phase
  task automatic t_rate(input logic [7:0] misc, input int x16, pre);
    int k, cnt;
    wr(fbg_pkg::ADDR_MISC, misc);
    set_div(x16);
    k = 0;
    cnt = 0;
    while (k < 2 && cnt < 2000) begin
      @(posedge clk);
      #1 cnt++;
      if (sample_tick === 1'b1) k++;
    end
    {k, cnt} = '0;
    while (k < 16 && cnt < 5000) begin
      @(posedge clk);
      #1 cnt++;
      if (sample_tick === 1'b1) k++;
    end
    chk("tick cycles", pre * x16, cnt);
  endtask : t_rate

  task automatic t_send(input logic [7:0] lc, ext, input logic [4:0] bt,
                        input logic pe, input logic [7:0] d);
    wr(fbg_pkg::ADDR_EXT_SEL, ext);
    wr(fbg_pkg::ADDR_LCTL, lc);
    {bit_ticks, par_en} = {bt, pe};
    wr(fbg_pkg::ADDR_HOLD, d);
    rd(fbg_pkg::ADDR_LSTATE);
    chk("shifter busy", 1'b0, r[fbg_pkg::LST_TX_EMPTY_BIT]);
    wait_rx(1);
    chk("line byte", {1'b0, d}, rxq.pop_front());
    repeat (20) @(posedge clk);
    rd(fbg_pkg::ADDR_LSTATE);
    chk("shifter empty", 1'b1, r[fbg_pkg::LST_TX_EMPTY_BIT]);
    chk("holding empty", 1'b1, r[fbg_pkg::LST_HOLD_EMPTY_BIT]);
  endtask : t_send

  // One byte leaves for the shifter, 64 fit, the last write is dropped
  task automatic t_fifo();
    int i;
    wr(fbg_pkg::ADDR_QCTL, 8'h01);
    {bit_ticks, par_en} = {5'h10, 1'b0};
    for (i = 0; i < 66; i++) wr(fbg_pkg::ADDR_HOLD, 8'(i));
    rd(fbg_pkg::ADDR_LSTATE);
    chk("fifo not empty", 1'b0, r[fbg_pkg::LST_HOLD_EMPTY_BIT]);
    wait_rx(65);
    for (i = 0; i < 65; i++) chk("fifo order", i, rxq.pop_front());
    repeat (400) @(posedge clk);
    chk("dropped byte", 0, rxq.size());
    rd(fbg_pkg::ADDR_LSTATE);
    chk("fifo empty", 1'b1, r[fbg_pkg::LST_HOLD_EMPTY_BIT]);
  endtask : t_fifo

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("mismatch watchdog expected 0 seen 1");
    wrap_up();
  end

  initial begin
    {sys_rst, wr_en, rd_en, addr, wr_data} = {1'b1, 13'h0};
    {bit_ticks, par_en, n_errors, tests_run} = '0;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk("idle line", 1'b1, tx_out);
    t_reset();
    t_rate(8'h00, 52, 1);
    t_rate(8'h80, 52, 4);
    t_rate(8'h00, 16, 1);
    t_send(8'h03, 8'h80, 5'h10, 1'b0, 8'ha5);
    t_send(8'h1b, 8'h00, 5'h08, 1'b1, 8'h38);
    wr(fbg_pkg::ADDR_EXT_SEL, 8'h80);
    wr(fbg_pkg::ADDR_LCTL, 8'h03);
    t_fifo();
    wrap_up();
  end
endmodule : tb_fractional_baud_gen_and_tx_front
